// [tcvb_map.svh]
`ifndef TCVB_MAP_SVH
`define TCVB_MAP_SVH
// ****************************************
// Register byte addresses
// ****************************************
`define TCVB_OFF_VALUE    12'h000
`define TCVB_OFF_CSC      12'h004
`define TCVB_OFF_MODULO   12'h008
`define TCVB_OFF_COUNTER  12'h00c
`define TCVB_OFF_CTRL     12'h010
`define TCVB_OFF_STATUS   12'h014
// ****************************************
// Field positions
// ****************************************
`define TCVB_CSC_MODE_LSB 0
`define TCVB_CSC_MODE_MSB 1
`define TCVB_CTRL_CLKS_LSB 0
`define TCVB_CTRL_CLKS_MSB 1
`define TCVB_CTRL_DEBUG    2
`define TCVB_CTRL_TICK     3
// ****************************************
// Reset values
// ****************************************
`define TCVB_RST_VALUE    16'h0000
`define TCVB_RST_MODULO   16'h0000
`define TCVB_RST_CSC      8'h00
`endif

// [tcvb_pkg.sv]
package tcvb_pkg;
  typedef enum logic [1:0] {
    TCVB_MODE_CAPTURE = 2'b00,
    TCVB_MODE_COMPARE = 2'b01,
    TCVB_MODE_PWM     = 2'b10,
    TCVB_MODE_OFF     = 2'b11
  } tcvb_mode_t;
  typedef enum logic [1:0] {
    TCVB_WR_IDLE    = 2'b00,
    TCVB_WR_HALF    = 2'b01,
    TCVB_WR_PENDING = 2'b10
  } tcvb_wr_t;
endpackage : tcvb_pkg

// [tcvb_counter.sv]
`timescale 1ns/1ps
`include "tcvb_map.svh"
module tcvb_counter (
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // Control
  input  wire logic        run,
  input  wire logic        tick,
  input  wire logic        clear,
  input  wire logic [15:0] modulo,
  // Counter state
  output logic      [15:0] count,
  output logic             step
);
  logic [15:0] limit;
  // Modulo zero means the counter runs free over the whole range
  assign limit = (modulo == 16'h0000) ? 16'hffff : modulo;
  assign step  = run && tick && !clear;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count <= 16'h0000;
    end else if (clear) begin
      count <= 16'h0000;
    end else if (step) begin
      count <= (count == limit) ? 16'h0000 : count + 16'h0001;
    end
  end
endmodule : tcvb_counter

// [tcvb_top.sv]
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/1ps
`include "tcvb_map.svh"
module tcvb_top #(
  parameter bit NEWER_REVISION = 1'b1
) (
  // AHB-Lite clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [11:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Channel state
  output logic      [15:0] channel_value_pair,
  output logic      [15:0] counter_value_pair
);
  import tcvb_pkg::*;
  // ****************************************
  // Bus address phase capture
  // ****************************************
  logic        ph_wr, ph_rd;
  logic [11:0] ph_addr;
  logic [2:0]  ph_size;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_wr   <= 1'b0;
      ph_rd   <= 1'b0;
      ph_addr <= 12'h000;
      ph_size <= 3'h0;
    end else if (hready) begin
      ph_wr   <= hsel && htrans[1] && hwrite;
      ph_rd   <= hsel && htrans[1] && !hwrite;
      ph_addr <= haddr;
      ph_size <= hsize;
    end
  end
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a[11:2] == off[11:2]);
  endfunction : hit

  // Byte accesses to the value word address one half; word access writes both
  logic lo_wr, hi_wr, lo_rd, hi_rd, val_wr, csc_wr;
  assign val_wr = ph_wr && hit(ph_addr, `TCVB_OFF_VALUE);
  assign lo_wr  = val_wr && (ph_size == 3'h2 || ph_addr[1:0] == 2'b00);
  assign hi_wr  = val_wr && (ph_size == 3'h2 || ph_addr[1:0] == 2'b01);
  assign lo_rd  = ph_rd && hit(ph_addr, `TCVB_OFF_VALUE) && (ph_size != 3'h2) && ph_addr[1:0] == 2'b00;
  assign hi_rd  = ph_rd && hit(ph_addr, `TCVB_OFF_VALUE) && (ph_size != 3'h2) && ph_addr[1:0] == 2'b01;
  assign csc_wr = ph_wr && hit(ph_addr, `TCVB_OFF_CSC);

  // ****************************************
  // Control registers
  // ****************************************
  logic [7:0]  csc;
  logic [15:0] modulo;
  logic [1:0]  clock_source_select;
  logic        background_debug_mode;
  logic        tick_mode;
  tcvb_mode_t  mode;
  assign mode = tcvb_mode_t'(csc[`TCVB_CSC_MODE_MSB:`TCVB_CSC_MODE_LSB]);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      csc                   <= `TCVB_RST_CSC;
      modulo                <= `TCVB_RST_MODULO;
      clock_source_select   <= 2'b00;
      background_debug_mode <= 1'b0;
      tick_mode             <= 1'b0;
    end else begin
      if (csc_wr) csc <= hwdata[7:0];
      if (ph_wr && hit(ph_addr, `TCVB_OFF_MODULO)) modulo <= hwdata[15:0];
      if (ph_wr && hit(ph_addr, `TCVB_OFF_CTRL)) begin
        clock_source_select   <= hwdata[`TCVB_CTRL_CLKS_MSB:`TCVB_CTRL_CLKS_LSB];
        background_debug_mode <= hwdata[`TCVB_CTRL_DEBUG];
        tick_mode             <= hwdata[`TCVB_CTRL_TICK];
      end
    end
  end

  // ****************************************
  // Counter and prescaler tick
  // ****************************************
  // Tick is every cycle unless software selects a divide-by-two enable
  logic tick_div, counter_step, counter_clear;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) tick_div <= 1'b0;
    else          tick_div <= !tick_div;
  end
  assign counter_clear = ph_wr && hit(ph_addr, `TCVB_OFF_COUNTER);
  tcvb_counter u_counter (
    .hclk    (hclk),
    .hresetn (hresetn),
    .run     ((clock_source_select != 2'b00) && !background_debug_mode),
    .tick    (tick_mode ? tick_div : 1'b1),
    .clear   (counter_clear),
    .modulo  (modulo),
    .count   (counter_value_pair),
    .step    (counter_step)
  );
  logic [15:0] limit;
  assign limit = (modulo == 16'h0000) ? 16'hffff : modulo;

  // ****************************************
  // Write buffer and value load
  // ****************************************
  logic [15:0] wbuf;
  tcvb_wr_t    wstate;
  logic        lo_seen, hi_seen, second_byte, load_now, capture_block;
  assign capture_block = NEWER_REVISION && mode == TCVB_MODE_CAPTURE;
  assign second_byte   = !capture_block && ((lo_wr || lo_seen) && (hi_wr || hi_seen)) && wstate != TCVB_WR_PENDING;
  always_comb begin
    load_now = 1'b0;
    if (wstate == TCVB_WR_PENDING) begin
      if (NEWER_REVISION && mode == TCVB_MODE_PWM)
        load_now = counter_step && counter_value_pair == limit - 16'h0001;
      else if (NEWER_REVISION)
        load_now = counter_step;
      else
        load_now = counter_step && counter_value_pair == limit;
    end
  end
  // No clock, off mode, or older compare or capture loads directly with the second byte
  logic direct;
  assign direct = second_byte && (clock_source_select == 2'b00 ||
                  mode == TCVB_MODE_CAPTURE || mode == TCVB_MODE_OFF ||
                  (!NEWER_REVISION && mode == TCVB_MODE_COMPARE));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wbuf               <= `TCVB_RST_VALUE;
      lo_seen            <= 1'b0;
      hi_seen            <= 1'b0;
      wstate             <= TCVB_WR_IDLE;
      channel_value_pair <= `TCVB_RST_VALUE;
    end else begin
      if (!capture_block && lo_wr) wbuf[7:0]  <= hwdata[7:0];
      if (!capture_block && hi_wr) wbuf[15:8] <= (ph_size == 3'h2) ? hwdata[15:8] : hwdata[15:8];
      if (second_byte) begin
        lo_seen <= 1'b0;
        hi_seen <= 1'b0;
      end else if (!capture_block) begin
        if (lo_wr) lo_seen <= 1'b1;
        if (hi_wr) hi_seen <= 1'b1;
      end
      if (direct) begin
        channel_value_pair <= {hi_wr ? hwdata[15:8] : wbuf[15:8], lo_wr ? hwdata[7:0] : wbuf[7:0]};
        wstate             <= TCVB_WR_IDLE;
      end else if (second_byte) begin
        wstate <= TCVB_WR_PENDING;
      end else if (load_now) begin
        channel_value_pair <= wbuf;
        wstate             <= TCVB_WR_IDLE;
      end else if ((lo_wr || hi_wr) && !capture_block && wstate == TCVB_WR_IDLE) begin
        wstate <= TCVB_WR_HALF;
      end
    end
  end

  // ****************************************
  // Read coherency latch
  // ****************************************
  // First byte read freezes the pair so the second byte matches it
  logic        rd_latched;
  logic [15:0] rd_buf;
  logic        latch_clr;
  assign latch_clr = NEWER_REVISION && background_debug_mode && csc_wr;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_latched <= 1'b0;
      rd_buf     <= 16'h0000;
    end else if (latch_clr) begin
      rd_latched <= 1'b0;
    end else if ((lo_rd || hi_rd) && !background_debug_mode) begin
      rd_latched <= !rd_latched;
      if (!rd_latched) rd_buf <= channel_value_pair;
    end
  end
  logic [15:0] rd_view;
  always_comb begin
    if (background_debug_mode)
      rd_view = (!NEWER_REVISION && rd_latched) ? rd_buf : channel_value_pair;
    else
      rd_view = rd_latched ? rd_buf : channel_value_pair;
  end

  // ****************************************
  // Read data
  // ****************************************
  logic [31:0] rdata_next;
  always_comb begin
    rdata_next = 32'h00000000;
    if (hit(haddr, `TCVB_OFF_VALUE))        rdata_next = {16'h0000, rd_view};
    else if (hit(haddr, `TCVB_OFF_CSC))     rdata_next = {24'h000000, csc};
    else if (hit(haddr, `TCVB_OFF_MODULO))  rdata_next = {16'h0000, modulo};
    else if (hit(haddr, `TCVB_OFF_COUNTER)) rdata_next = {16'h0000, counter_value_pair};
    else if (hit(haddr, `TCVB_OFF_CTRL))    rdata_next = {28'h0000000, tick_mode, background_debug_mode, clock_source_select};
    else if (hit(haddr, `TCVB_OFF_STATUS))  rdata_next = {28'h0000000, rd_latched, hi_seen, wstate};
  end
  // Read data registered at address phase; the value view then shows the latch state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) hrdata <= 32'h00000000;
    else if (hready && hsel && htrans[1] && !hwrite) hrdata <= rdata_next;
  end

  // ****************************************
  // Checks
  // ****************************************
  // Debug reads are checked at the bus, so a broken read mux is caught and not only the view
  logic value_rd_req;
  assign value_rd_req = hready && hsel && htrans[1] && !hwrite && hit(haddr, `TCVB_OFF_VALUE);
  property p_newer_debug_live;
    @(posedge hclk) disable iff (!hresetn)
      (NEWER_REVISION && background_debug_mode && value_rd_req) |=> hrdata[15:0] == $past(channel_value_pair);
  endproperty
  a_newer_debug_live: assert property (p_newer_debug_live) else $error("debug read not live");
  property p_older_debug_latch;
    @(posedge hclk) disable iff (!hresetn)
      (!NEWER_REVISION && background_debug_mode && rd_latched && value_rd_req) |=> hrdata[15:0] == $past(rd_buf);
  endproperty
  a_older_debug_latch: assert property (p_older_debug_latch) else $error("debug read not latched");
  property p_newer_clear;
    @(posedge hclk) disable iff (!hresetn)
      (NEWER_REVISION && background_debug_mode && csc_wr) |=> !rd_latched;
  endproperty
  a_newer_clear: assert property (p_newer_clear) else $error("latch not cleared");
  property p_older_keep;
    @(posedge hclk) disable iff (!hresetn)
      (!NEWER_REVISION && background_debug_mode && csc_wr && !lo_rd && !hi_rd) |=> $stable(rd_latched);
  endproperty
  a_older_keep: assert property (p_older_keep) else $error("latch changed");
  property p_capture_block;
    @(posedge hclk) disable iff (!hresetn)
      (capture_block && val_wr) |=> $stable(wbuf);
  endproperty
  a_capture_block: assert property (p_capture_block) else $error("capture write taken");
  property p_pwm_load;
    @(posedge hclk) disable iff (!hresetn)
      (NEWER_REVISION && mode == TCVB_MODE_PWM && wstate == TCVB_WR_PENDING && !$changed(channel_value_pair))
      ##1 $changed(channel_value_pair) |-> counter_value_pair == limit;
  endproperty
  a_pwm_load: assert property (p_pwm_load) else $error("pwm load off edge");
  property p_no_clock_load;
    @(posedge hclk) disable iff (!hresetn)
      (direct && clock_source_select == 2'b00) |=> wstate == TCVB_WR_IDLE && channel_value_pair == wbuf;
  endproperty
  a_no_clock_load: assert property (p_no_clock_load) else $error("no clock load late");
  property p_older_compare;
    @(posedge hclk) disable iff (!hresetn)
      (!NEWER_REVISION && mode == TCVB_MODE_COMPARE && second_byte) |=> wstate == TCVB_WR_IDLE &&
      channel_value_pair == wbuf;
  endproperty
  a_older_compare: assert property (p_older_compare) else $error("compare load late");
  property p_newer_compare;
    @(posedge hclk) disable iff (!hresetn)
      (NEWER_REVISION && mode == TCVB_MODE_COMPARE && wstate == TCVB_WR_PENDING && counter_step)
      |=> channel_value_pair == $past(wbuf);
  endproperty
  a_newer_compare: assert property (p_newer_compare) else $error("compare load missing");
  property p_older_pwm;
    @(posedge hclk) disable iff (!hresetn)
      (!NEWER_REVISION && load_now) |=> counter_value_pair == 16'h0000;
  endproperty
  a_older_pwm: assert property (p_older_pwm) else $error("pwm load not at wrap");
  c_pending: cover property (@(posedge hclk) wstate == TCVB_WR_PENDING ##[1:20] wstate == TCVB_WR_IDLE);
  c_debug_latch: cover property (@(posedge hclk) background_debug_mode && rd_latched);
  c_csc_clear: cover property (@(posedge hclk) latch_clr && rd_latched);
endmodule : tcvb_top

// [tcvb_host.sv]
`timescale 1ns/1ps
module tcvb_host (
  // Bus clock
  input  wire logic        hclk,
  // Slave answers
  input  wire logic        hready_a,
  input  wire logic        hready_b,
  input  wire logic [31:0] hrdata_a,
  input  wire logic [31:0] hrdata_b,
  // Master request
  output logic             hsel,
  output logic      [11:0] haddr,
  output logic      [1:0]  htrans,
  output logic             hwrite,
  output logic      [2:0]  hsize,
  output logic      [31:0] hwdata
);
  initial begin
    hsel = 1'b1;
    haddr = 12'h000;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end
  // Both slaves see one request, so the handshake waits for both
  task automatic xfer(input logic w, input logic [11:0] a, input logic [2:0] sz, input logic [31:0] d,
                      output logic [31:0] qa, output logic [31:0] qb);
    @(posedge hclk);
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= w;
    hsize <= sz;
    do @(posedge hclk); while ((hready_a & hready_b) !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while ((hready_a & hready_b) !== 1'b1);
    qa = hrdata_a;
    qb = hrdata_b;
  endtask : xfer
endmodule : tcvb_host

// [timer_channel_value_buffer_tb.sv]
`timescale 1ns/1ps
`include "tcvb_map.svh"
module timer_channel_value_buffer_tb;
  import tcvb_pkg::*;
  logic        hclk, hresetn, hsel, hwrite, rdy_n, rdy_o, resp_n, resp_o;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, rd_n, rd_o, qn, qo;
  logic [15:0] cv_n, cv_o, cnt_n, cnt_o, v, vn, vo, lat, m, cn, co;
  logic [31:0] tick;
  int          error_cnt = 0;
  int          num_checks = 0;
  // ****************************************
  // Parts
  // ****************************************
  tcvb_host host_u (.hclk(hclk), .hready_a(rdy_n), .hready_b(rdy_o), .hrdata_a(rd_n), .hrdata_b(rd_o),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
  tcvb_top #(.NEWER_REVISION(1'b1)) dut_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy_n), .hrdata(rd_n),
    .hreadyout(rdy_n), .hresp(resp_n), .channel_value_pair(cv_n), .counter_value_pair(cnt_n));
  tcvb_top #(.NEWER_REVISION(1'b0)) dut_old_u (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(rdy_o), .hrdata(rd_o),
    .hreadyout(rdy_o), .hresp(resp_o), .channel_value_pair(cv_o), .counter_value_pair(cnt_o));
  // ****************************************
  // Helpers
  // ****************************************
  function automatic logic [15:0] exp_now(input bit nw, input tcvb_mode_t md, input logic [1:0] k,
                                          input logic [15:0] old, input logic [15:0] d);
    if (nw)
      return (k == 2'b00 && md != TCVB_MODE_CAPTURE) ? d : old;
    return (md == TCVB_MODE_PWM && k != 2'b00) ? old : d;
  endfunction : exp_now
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp, input string what);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk16
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    host_u.xfer(1'b1, a, 3'h2, d, qn, qo);
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [2:0] sz);
    host_u.xfer(1'b0, a, sz, 32'h0, qn, qo);
  endtask : rd
  // Short write paths settle within two edges
  task automatic put(input tcvb_mode_t md, input logic [1:0] k, input logic [15:0] d);
    wr(`TCVB_OFF_VALUE, {16'h0, d});
    repeat (2) @(posedge hclk);
    #1;
    vn = exp_now(1'b1, md, k, vn, d);
    vo = exp_now(1'b0, md, k, vo, d);
    chk16(cv_n, vn, "newer value");
    chk16(cv_o, vo, "older value");
  endtask : put
  // Records the counter at the edge where each revision loads d
  task automatic run_until(input logic [15:0] d);
    bit dn = 1'b0;
    bit dd = 1'b0;
    cn = 'x;
    co = 'x;
    for (int i = 0; i < 400 && !(dn && dd); i++) begin
      @(posedge hclk);
      #1;
      if (!dn && cv_n === d) begin
        dn = 1'b1;
        cn = cnt_n;
      end
      if (!dd && cv_o === d) begin
        dd = 1'b1;
        co = cnt_o;
      end
    end
  endtask : run_until
  task test_done;
    if (error_cnt == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  // ****************************************
  // Stimulus
  // ****************************************
  initial begin
    hclk = 1'b0;
    forever #2.5 hclk = ~hclk;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    test_done;
  end
  initial begin
    hresetn = 1'b0;
    vn = 16'h0;
    vo = 16'h0;
    void'($urandom(32'h9128));
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    wr(`TCVB_OFF_CTRL, 32'h0);
    wr(`TCVB_OFF_CSC, {30'h0, TCVB_MODE_CAPTURE});
    v = 16'($urandom) | 16'h1;
    put(TCVB_MODE_CAPTURE, 2'b00, v);
    wr(`TCVB_OFF_CSC, {30'h0, TCVB_MODE_COMPARE});
    put(TCVB_MODE_COMPARE, 2'b00, v ^ 16'h00ff);
    lat = vn;
    rd(`TCVB_OFF_VALUE, 3'h0);
    wr(`TCVB_OFF_CTRL, 32'h4);
    put(TCVB_MODE_COMPARE, 2'b00, vn ^ 16'h0f00);
    rd(`TCVB_OFF_VALUE, 3'h2);
    chk16(qn[15:0], vn, "debug read newer");
    chk16(qo[15:0], lat, "debug read older");
    wr(`TCVB_OFF_CSC, {30'h0, TCVB_MODE_COMPARE});
    rd(`TCVB_OFF_STATUS, 3'h2);
    chk16({15'h0, qn[3]}, 16'h0, "latch newer");
    chk16({15'h0, qo[3]}, 16'h1, "latch older");
    for (int i = 0; i < 3; i++) begin
      m = 16'h4 + 16'($urandom % 8);
      tick = $urandom & 32'h8;
      wr(`TCVB_OFF_MODULO, {16'h0, m});
      wr(`TCVB_OFF_CTRL, 32'h6 | tick);
      wr(`TCVB_OFF_COUNTER, 32'h0);
      wr(`TCVB_OFF_CSC, {30'h0, TCVB_MODE_COMPARE});
      v = vn ^ (16'h1 << ($urandom % 16));
      put(TCVB_MODE_COMPARE, 2'b01, v);
      wr(`TCVB_OFF_CTRL, 32'h2 | tick);
      run_until(v);
      chk16(cn, 16'h1, "compare load count");
      vn = v;
      wr(`TCVB_OFF_CTRL, 32'h6 | tick);
      wr(`TCVB_OFF_COUNTER, 32'h0);
      wr(`TCVB_OFF_CSC, {30'h0, TCVB_MODE_PWM});
      v = vn ^ (16'h1 << ($urandom % 16));
      put(TCVB_MODE_PWM, 2'b01, v);
      wr(`TCVB_OFF_CTRL, 32'h2 | tick);
      run_until(v);
      chk16(cn, m, "pwm load newer");
      chk16(co, 16'h0, "pwm load older");
      vn = v;
      vo = v;
    end
    chk16({14'h0, resp_o, resp_n}, 16'h0, "response not okay");
    test_done;
  end
endmodule : timer_channel_value_buffer_tb
